// [design/fdc_pkg.sv]
// constants, register map and field layout of the converter fault and mode control
// assumes one 40 MHz clock and an AXI4-Lite master on the register side
// Notes on behaviour
// - reset low gives shutdown and default registers
// - current ramps; ramp-up pauses out of regulation
// - high level, switching on, no boost: PWM after startup
// - switching off: never 1MHz, skip per enable
// - switching on: high gives 4/1MHz, low per skip
// - boost set forces switching enable to zero
// - overvoltage always forces pulse skipping
// - reading fault register clears fault flags
// - thermistor, timeout and open or short faults not met by a single LED disable stop converter, clear mode fields
// - overvoltage plus low headroom: open LED fault
// - single open LED of two: disable it
// - no open detection in mode 01
// - no open fault in constant-voltage mode
// - short check above current threshold after startup
// - single shorted LED of two: disable it
// - no short detection in mode 01
// - overtemperature stops at once, mode kept
// - overtemperature restarts on cooling, except constant-voltage
// - transmit mask during flash sets flag and txmask_reduce, no stop
// - strobe-length flash past timeout: stop, ramp down
// - timer-length flash sets timeout flag at end
// - undervoltage holds shutdown and default registers
// - thermistor trip when enabled: stop, flag
package fdc_pkg;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned RAMP_FULL_US  = 500;
  localparam int unsigned RAMP_STEP_CYC = RAMP_FULL_US * CLK_MHZ / 255;
  localparam int unsigned TMO_STEP_US   = 4000;
  localparam int unsigned TMO_STEP_CYC  = TMO_STEP_US * CLK_MHZ;
  localparam int unsigned SHORT_DEB_US  = 10;
  localparam int unsigned SHORT_DEB_CYC = SHORT_DEB_US * CLK_MHZ;
  localparam int unsigned LSB_UA        = 7830;
  localparam int unsigned SHORT_UA      = 27500;
  localparam int unsigned SHORT_B_UA    = 34300;
  localparam logic [7:0]  SHORT_CODE    = 8'((SHORT_UA + LSB_UA - 1) / LSB_UA);
  localparam logic [7:0]  SHORT_CODE_B  = 8'((SHORT_B_UA + LSB_UA - 1) / LSB_UA);
  localparam logic [7:0]  HIGH_LEVEL    = 8'h40;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_LEVEL   = 8'h04;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
  localparam logic [7:0] ADDR_FAULT   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_PWM   = 2'h1;
  localparam logic [1:0] MODE_TORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  localparam logic [1:0] TXM_OFF    = 2'h0;
  localparam logic [1:0] TXM_MASK   = 2'h1;

  localparam int F_OPEN  = 0;
  localparam int F_SHORT = 1;
  localparam int F_HOT   = 2;
  localparam int F_TXM   = 3;
  localparam int F_TMO   = 4;
  localparam int F_NTC   = 5;
  localparam int NFLT    = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/fdc_ctrl.sv]
// converter mode selection, protection sequencing and AXI4-Lite registers
// comparator and pin inputs are asynchronous and synchronised here
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fdc_ctrl #(
  parameter int unsigned TMO_STEP = fdc_pkg::TMO_STEP_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        strobe_pin,
  input  wire logic        txmask_pin,
  input  wire logic        vout_over,
  input  wire logic [1:0]  low_headroom,
  input  wire logic [1:0]  below_short,
  input  wire logic        die_hot,
  input  wire logic        die_cooled,
  input  wire logic        thermistor_trip,
  input  wire logic        vin_under,
  input  wire logic        out_of_reg,
  output logic             dcdc_en,
  output logic [1:0]       source_en,
  output logic [7:0]       first_led_level,
  output logic [7:0]       second_led_level,
  output logic             allow_1mhz,
  output logic             skip_allowed,
  output logic             skip_force,
  output logic             txmask_reduce
);
  import fdc_pkg::*;

  localparam int NSYNC = 12;

  logic [NSYNC-1:0] sy1;
  logic [NSYNC-1:0] sy2;
  logic [NSYNC-1:0] async_in;
  assign async_in = {out_of_reg, vin_under, thermistor_trip, die_cooled, die_hot,
                     below_short, low_headroom, vout_over, txmask_pin, strobe_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          sy1[gi] <= 1'b0;
          sy2[gi] <= 1'b0;
        end else begin
          sy1[gi] <= async_in[gi];
          sy2[gi] <= sy1[gi];
        end
      end
    end
  endgenerate

  logic       strobe_s, txmask_s, ovp_s, hot_s, cool_s, ntc_s, uvlo_s, oor_s;
  logic [1:0] lowvds_s, short_s;
  assign {oor_s, uvlo_s, ntc_s, cool_s, hot_s, short_s, lowvds_s, ovp_s, txmask_s,
          strobe_s} = sy2;

  // shutdown: reset pin or supply undervoltage
  logic clr;
  assign clr = !rstn || uvlo_s;

  // configuration
  logic [1:0] mode, txm_mode;
  logic       strobe_on, strobe_type, freq_sw, skip_en, boost, const_v, ntc_on, dual;
  logic [7:0] level1, level2, tmo_code;
  logic [NFLT-1:0] fault, evt;
  logic       wr_ctrl, flash_req, rd_fault;

  // bus write channel
  logic        aw_have, w_have;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_wr;
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;
  assign do_wr = aw_have && w_have;

  always_ff @(posedge mclk) begin
    if (clr) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_LEVEL ||
                        aw_addr == ADDR_TIMEOUT) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_ctrl   = do_wr && aw_addr == ADDR_CTRL && w_strb[0];
  assign flash_req = wr_ctrl && w_data[1:0] == MODE_FLASH && !w_data[4];

  // protection and flash state
  logic       hot_hold, flash_on, started;
  logic [1:0] led_off;
  logic [31:0] tmo_cnt;
  logic       strobe_d, strobe_rise, tmo_hit, run, all_stop;
  logic [1:0] open_evt, short_evt, single_ok;
  logic [7:0] tgt1, tgt2;

  assign strobe_rise = strobe_s && !strobe_d;
  assign tmo_hit = flash_on && tmo_cnt >= ({24'h0, tmo_code} + 32'h1) * TMO_STEP;
  assign run = mode != MODE_OFF && !hot_hold && led_off != 2'b11 &&
               (mode != MODE_FLASH || flash_on);

  // per LED fault detection
  logic [8:0] short_cnt [2];
  logic [1:0] led_over;
  assign led_over[0] = first_led_level > (boost ? SHORT_CODE_B : SHORT_CODE);
  assign led_over[1] = second_led_level > (boost ? SHORT_CODE_B : SHORT_CODE);
  generate
    for (gi = 0; gi < 2; gi++) begin : g_led
      assign open_evt[gi] = source_en[gi] && ovp_s && lowvds_s[gi] &&
                            mode != MODE_PWM && !const_v;
      assign short_evt[gi] = short_cnt[gi] == 9'(SHORT_DEB_CYC) && mode != MODE_PWM;
      assign single_ok[gi] = dual && !led_off[1-gi] && !open_evt[1-gi] &&
                             !short_evt[1-gi];
      always_ff @(posedge mclk) begin
        if (clr || !short_s[gi] || !started || !source_en[gi] || mode == MODE_PWM ||
            !led_over[gi]) begin
          short_cnt[gi] <= 9'h0;
        end else if (!short_evt[gi]) begin
          short_cnt[gi] <= short_cnt[gi] + 9'h1;
        end
      end
    end
  endgenerate

  logic ntc_evt;
  assign ntc_evt = ntc_on && ntc_s && run;
  assign all_stop = ntc_evt || ((open_evt[0] || short_evt[0]) && !single_ok[0]) ||
                    ((open_evt[1] || short_evt[1]) && !single_ok[1]);

  always_comb begin
    evt = '0;
    evt[F_OPEN]  = |open_evt;
    evt[F_SHORT] = |short_evt;
    evt[F_HOT]   = hot_s && !hot_hold;
    evt[F_TXM]   = flash_on && txm_mode == TXM_MASK && txmask_s;
    evt[F_TMO]   = tmo_hit;
    evt[F_NTC]   = ntc_evt;
  end

  // configuration registers; thermistor, timeout and open or short faults not met by a single LED disable clear mode fields
  always_ff @(posedge mclk) begin
    if (clr) begin
      {mode, txm_mode} <= {MODE_OFF, TXM_OFF};
      {strobe_on, strobe_type, freq_sw, skip_en, boost, const_v, ntc_on, dual} <= 8'h00;
      level1 <= 8'h00;
      level2 <= 8'h00;
      tmo_code <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        mode <= w_data[1:0];
        txm_mode <= w_data[3:2];
        strobe_on <= w_data[4];
        strobe_type <= w_data[5];
        freq_sw <= w_data[6] && !(w_strb[1] ? w_data[8] : boost);
        skip_en <= w_data[7];
      end
      if (do_wr && aw_addr == ADDR_CTRL && w_strb[1]) begin
        boost <= w_data[8];
        const_v <= w_data[9];
        ntc_on <= w_data[10];
        dual <= w_data[11];
        if (w_data[8]) begin
          freq_sw <= 1'b0;
        end
      end
      if (do_wr && aw_addr == ADDR_LEVEL) begin
        if (w_strb[0]) level1 <= w_data[7:0];
        if (w_strb[1]) level2 <= w_data[15:8];
      end
      if (do_wr && aw_addr == ADDR_TIMEOUT && w_strb[0]) begin
        tmo_code <= w_data[7:0];
      end
      if (all_stop || tmo_hit) begin
        mode <= MODE_OFF;
        txm_mode <= TXM_OFF;
      end
    end
  end

  // flash timer
  always_ff @(posedge mclk) begin
    if (clr) begin
      flash_on <= 1'b0;
      tmo_cnt <= 32'h0;
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= strobe_s;
      if (!flash_on) begin
        tmo_cnt <= 32'h0;
        flash_on <= flash_req || (mode == MODE_FLASH && strobe_on && strobe_rise);
      end else if (tmo_hit || all_stop || mode != MODE_FLASH || hot_hold ||
                   (strobe_on && strobe_type && !strobe_s)) begin
        flash_on <= 1'b0;
        tmo_cnt <= 32'h0;
      end else begin
        tmo_cnt <= tmo_cnt + 32'h1;
      end
    end
  end

  // overtemperature hold and per LED disable
  always_ff @(posedge mclk) begin
    if (clr) begin
      hot_hold <= 1'b0;
      led_off <= 2'b00;
    end else begin
      if (hot_s) begin
        hot_hold <= 1'b1;
      end else if (hot_hold && cool_s && (!const_v || wr_ctrl)) begin
        hot_hold <= 1'b0;
      end
      if (wr_ctrl) begin
        led_off <= 2'b00;
      end
      for (int i = 0; i < 2; i++) begin
        if ((open_evt[i] || short_evt[i]) && single_ok[i]) begin
          led_off[i] <= 1'b1;
        end
      end
    end
  end

  // fault flags: new events win over the clearing read
  always_ff @(posedge mclk) begin
    if (clr) begin
      fault <= '0;
    end else begin
      fault <= (rd_fault ? '0 : fault) | evt;
    end
  end

  // source enables and soft ramp
  logic [6:0] ramp_div;
  logic       ramp_tick;
  assign ramp_tick = ramp_div == 7'(RAMP_STEP_CYC - 1);
  assign tgt1 = !source_en[0] ? 8'h00 : (mode == MODE_FLASH ? level1 : {2'b00, level1[5:0]});
  assign tgt2 = !source_en[1] ? 8'h00 : (mode == MODE_FLASH ? level2 : {2'b00, level2[5:0]});

  function automatic logic [7:0] ramp_step(input logic [7:0] cur, input logic [7:0] tgt,
                                           input logic hold_up);
    if (cur < tgt && !hold_up) return cur + 8'h01;
    if (cur > tgt) return cur - 8'h01;
    return cur;
  endfunction

  always_ff @(posedge mclk) begin
    if (clr) begin
      dcdc_en <= 1'b0;
      source_en <= 2'b00;
      first_led_level <= 8'h00;
      second_led_level <= 8'h00;
      ramp_div <= 7'h0;
      started <= 1'b0;
    end else begin
      dcdc_en <= run && !all_stop && !hot_s;
      source_en <= (run && !all_stop && !hot_s) ? ~led_off & ~(open_evt | short_evt) : 2'b00;
      ramp_div <= ramp_tick ? 7'h0 : ramp_div + 7'h1;
      if (all_stop || hot_s || hot_hold) begin
        first_led_level <= 8'h00;
        second_led_level <= 8'h00;
      end else if (ramp_tick) begin
        first_led_level <= ramp_step(first_led_level, tgt1, oor_s);
        second_led_level <= ramp_step(second_led_level, tgt2, oor_s);
      end
      if (!dcdc_en) begin
        started <= 1'b0;
      end else if (first_led_level == tgt1 && second_led_level == tgt2) begin
        started <= 1'b1;
      end
    end
  end

  // switching regime
  logic hi_load, fs_hi;
  assign hi_load = level1 >= HIGH_LEVEL || level2 >= HIGH_LEVEL;
  assign fs_hi = freq_sw && !boost && hi_load;
  always_ff @(posedge mclk) begin
    if (clr) begin
      allow_1mhz <= 1'b0;
      skip_allowed <= 1'b0;
      skip_force <= 1'b0;
      txmask_reduce <= 1'b0;
    end else begin
      allow_1mhz <= fs_hi;
      skip_allowed <= fs_hi ? !started : skip_en;
      skip_force <= ovp_s;
      txmask_reduce <= flash_on && txm_mode == TXM_MASK && txmask_s;
    end
  end

  // bus read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fault = s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_FAULT;
  always_ff @(posedge mclk) begin
    if (clr) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:    s_axi_rdata <= {20'h0, dual, ntc_on, const_v, boost, skip_en,
                                      freq_sw, strobe_type, strobe_on, txm_mode, mode};
        ADDR_LEVEL:   s_axi_rdata <= {16'h0, level2, level1};
        ADDR_TIMEOUT: s_axi_rdata <= {24'h0, tmo_code};
        ADDR_FAULT:   s_axi_rdata <= {26'h0, fault};
        ADDR_STATUS:  s_axi_rdata <= {8'h0, second_led_level, first_led_level, 1'b0,
                                      skip_allowed, allow_1mhz, hot_hold, led_off,
                                      started, dcdc_en};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_fault_read_clr: assert property (@(posedge mclk) disable iff (clr)
    rd_fault && evt == '0 |=> fault == '0) else $error("fault not cleared by read");
  a_set_wins_read: assert property (@(posedge mclk) disable iff (clr)
    rd_fault |=> &(fault | ~$past(evt))) else $error("fault lost on read");
  a_boost_fs_off: assert property (@(posedge mclk) disable iff (clr)
    boost |-> !freq_sw) else $error("switching enabled with boost");
  a_no_1mhz_off: assert property (@(posedge mclk) disable iff (clr)
    !freq_sw ##1 !$past(clr) |-> !allow_1mhz) else $error("1MHz with switching off");
  a_ovp_skip_on: assert property (@(posedge mclk) disable iff (clr)
    ovp_s |=> skip_force) else $error("no skip on overvoltage");
  a_ntc_stop: assert property (@(posedge mclk) disable iff (clr)
    ntc_evt |=> !dcdc_en && fault[F_NTC] && mode == MODE_OFF)
    else $error("no thermistor stop");
  a_hot_keep_mode: assert property (@(posedge mclk) disable iff (clr)
    hot_s && !all_stop && !wr_ctrl && !tmo_hit |=> !dcdc_en && $stable(mode))
    else $error("overtemp");
  a_pwm_no_open: assert property (@(posedge mclk) disable iff (clr)
    mode == MODE_PWM |-> !evt[F_OPEN] && !evt[F_SHORT]) else $error("fault in mode 01");
  a_ramp_pause: assert property (@(posedge mclk) disable iff (clr)
    oor_s && ramp_tick && first_led_level < tgt1 && !hot_s && !all_stop |=>
    first_led_level == $past(first_led_level)) else $error("ramp not paused");
  a_uvlo_shut: assert property (@(posedge mclk)
    uvlo_s ##1 uvlo_s |-> mode == MODE_OFF && !dcdc_en) else $error("active in undervoltage");

  c_flash_tmo: cover property (@(posedge mclk) disable iff (clr) tmo_hit);
  c_single_off: cover property (@(posedge mclk) disable iff (clr) led_off == 2'b01 && dcdc_en);
  c_hot_restart: cover property (@(posedge mclk) disable iff (clr) hot_hold ##1 !hot_hold);
  c_txmask: cover property (@(posedge mclk) disable iff (clr) evt[F_TXM] ##1 dcdc_en);
endmodule

// [sim/fdc_plant.sv]
// analog stage model: comparators and converter seen by the control block
// assumes bench commands for open, shorted, overvoltage and stall cases
`timescale 1ns/1ps
module fdc_plant (
  input  wire logic       dcdc_en,
  input  wire logic [1:0] source_en,
  input  wire logic [1:0] open_cmd,
  input  wire logic [1:0] short_cmd,
  input  wire logic       ovp_cmd,
  input  wire logic       stall,
  output logic            vout_over,
  output logic [1:0]      low_headroom,
  output logic [1:0]      below_short,
  output logic            out_of_reg
);
  // open string: output climbs to its limit only while a dead source runs
  assign low_headroom = open_cmd & source_en;
  assign vout_over    = ovp_cmd | (dcdc_en & (|low_headroom));
  assign below_short  = short_cmd & source_en;
  // slow converter: loses regulation while asked to stall
  assign out_of_reg   = dcdc_en & stall;
endmodule

// [sim/fdc_ctrl_test.sv]
// self-checking bench for fdc_ctrl beside the analog stage model
// assumes the register map of fdc_pkg and a 20-cycle timeout step
`timescale 1ns/1ps
module fdc_ctrl_test;
  import fdc_pkg::*;
  localparam int unsigned STEP  = 20;
  localparam int          LIMIT = 95000;
  logic        mclk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, strobe_pin, txmask_pin;
  logic        die_hot, die_cooled, thermistor_trip, vin_under, vout_over, out_of_reg;
  logic        dcdc_en, allow_1mhz, skip_allowed, skip_force, txmask_reduce, ovp_cmd, stall;
  logic [7:0]  awaddr, araddr, first_led_level, second_led_level;
  logic [31:0] wdata, rdata, got, lv;
  logic [1:0]  bresp, rresp, low_headroom, below_short, source_en, open_cmd, short_cmd;
  logic        hi, fs;
  int          num_errors, cmp_count, cyc, exp_ctrl;

  fdc_ctrl #(.TMO_STEP(STEP)) fdc_ctrl_inst (
    .mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .strobe_pin(strobe_pin), .txmask_pin(txmask_pin), .vout_over(vout_over),
    .low_headroom(low_headroom), .below_short(below_short), .die_hot(die_hot),
    .die_cooled(die_cooled), .thermistor_trip(thermistor_trip), .vin_under(vin_under),
    .out_of_reg(out_of_reg), .dcdc_en(dcdc_en), .source_en(source_en),
    .first_led_level(first_led_level), .second_led_level(second_led_level),
    .allow_1mhz(allow_1mhz), .skip_allowed(skip_allowed), .skip_force(skip_force),
    .txmask_reduce(txmask_reduce));

  fdc_plant fdc_plant_inst (
    .dcdc_en(dcdc_en), .source_en(source_en), .open_cmd(open_cmd),
    .short_cmd(short_cmd), .ovp_cmd(ovp_cmd), .stall(stall), .vout_over(vout_over),
    .low_headroom(low_headroom), .below_short(below_short), .out_of_reg(out_of_reg));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      $display("MISMATCH t=%0t run did not finish in time", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // master: valid and payload held until the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge mclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      if (b_t) chk(32'(bresp), 32'(er));
      @(posedge mclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar_t, r_t;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge mclk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      if (r_t) chk(32'(rresp), 32'(er));
      @(posedge mclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, RESP_OKAY);
    chk(d, e);
  endtask

  task automatic calm();
    {strobe_pin, txmask_pin, die_hot, die_cooled, thermistor_trip} <= 5'h00;
    {vin_under, ovp_cmd, stall, open_cmd, short_cmd} <= 7'h00;
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk);
    rstn <= 1'b0;
    calm();
    repeat (n) @(posedge mclk);
    rstn <= 1'b1;
    exp_ctrl = 0;
    @(negedge mclk);
    chk(32'({dcdc_en, source_en, allow_1mhz, skip_allowed, skip_force, txmask_reduce,
             first_led_level, second_led_level}), 32'h0);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    wr(ADDR_CTRL, v, RESP_OKAY);
    exp_ctrl = v[8] ? v & ~32'h40 : v;
  endtask

  task automatic wait_start();
    logic [31:0] s;
    int n;
    n = 0;
    s = '0;
    while (!s[1] && n < 3000) begin
      rd(ADDR_STATUS, s, RESP_OKAY);
      n++;
    end
  endtask

  task automatic start(input logic [31:0] v, input logic [7:0] tmo);
    do_reset(3);
    wr(ADDR_LEVEL, 32'h2020, RESP_OKAY);
    wr(ADDR_TIMEOUT, 32'(tmo), RESP_OKAY);
    set_ctrl(v);
    strobe_pin <= v[4];
    wait_start();
  endtask

  // pins, then fault flags, then mode fields after a fault
  task automatic verdict(input int n, input logic [31:0] ef, input int es,
                         input logic [31:0] ec);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
    if (es >= 0) chk(32'({dcdc_en, source_en}), 32'(es));
    rdc(ADDR_FAULT, ef);
    rdc(ADDR_CTRL, ec);
  endtask

  initial begin
    calm();
    {rstn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
    {awaddr, araddr, wdata} <= 48'h0;
    void'($urandom(32'he1e7ead2));
    do_reset(12);
    rdc(ADDR_CTRL, 32'h0);
    rd(8'h40, got, RESP_SLVERR);
    chk(got, 32'h0);
    wr(ADDR_FAULT, 32'h3f, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      lv = $urandom;
      if (lv[15:8] > lv[7:0]) lv[15:8] = lv[7:0];
      hi = (lv[7:0] >= HIGH_LEVEL) || (lv[15:8] >= HIGH_LEVEL);
      fs = i[0] & ~i[2];
      wr(ADDR_LEVEL, {16'h0, lv[15:0]}, RESP_OKAY);
      set_ctrl(32'h2 | 32'(i << 6));
      wait_start();
      @(negedge mclk);
      chk(32'({allow_1mhz, skip_allowed}), 32'({fs & hi, i[1] & ~(fs & hi)}));
      rdc(ADDR_CTRL, exp_ctrl);
    end
    ovp_cmd <= 1'b1;
    verdict(4, 32'h0, -1, exp_ctrl);
    @(negedge mclk);
    chk(32'(skip_force), 32'h1);
    do_reset(3);
    wr(ADDR_LEVEL, 32'h1010, RESP_OKAY);
    set_ctrl(32'h2);
    for (int n = 0; n < 2000 && first_led_level < 8'h04; n++) @(posedge mclk);
    stall <= 1'b1;
    repeat (4) @(posedge mclk);
    lv = 32'(first_led_level);
    repeat (300) @(posedge mclk);
    chk(32'(first_led_level), lv);
    stall <= 1'b0;
    wait_start();
    repeat (200) @(posedge mclk);
    chk(32'(first_led_level), 32'h10);
    start(32'h2, 8'hff);
    open_cmd <= 2'b11;
    verdict(10, 32'h1, 0, exp_ctrl & ~32'hf);
    rdc(ADDR_FAULT, 32'h0);
    start(32'h802, 8'hff);
    open_cmd <= 2'b01;
    verdict(10, 32'h1, 6, exp_ctrl);
    start(32'h2, 8'hff);
    short_cmd <= 2'b11;
    verdict(500, 32'h2, 0, exp_ctrl & ~32'hf);
    start(32'h802, 8'hff);
    short_cmd <= 2'b10;
    verdict(500, 32'h2, 5, exp_ctrl);
    start(32'h1, 8'hff);
    {open_cmd, short_cmd} <= 4'hf;
    verdict(500, 32'h0, -1, exp_ctrl);
    start(32'h202, 8'hff);
    open_cmd <= 2'b11;
    verdict(50, 32'h0, -1, exp_ctrl);
    start(32'h2, 8'hff);
    die_hot <= 1'b1;
    verdict(6, 32'h4, 0, exp_ctrl);
    {die_hot, die_cooled} <= 2'b01;
    wait_start();
    @(negedge mclk);
    chk(32'(dcdc_en), 32'h1);
    start(32'h202, 8'hff);
    die_hot <= 1'b1;
    repeat (6) @(posedge mclk);
    {die_hot, die_cooled} <= 2'b01;
    verdict(200, 32'h4, 0, exp_ctrl);
    start(32'h402, 8'hff);
    thermistor_trip <= 1'b1;
    verdict(6, 32'h20, 0, exp_ctrl & ~32'hf);
    start(32'h37, 8'hff);
    txmask_pin <= 1'b1;
    verdict(10, 32'h8, -1, exp_ctrl);
    rdc(ADDR_FAULT, 32'h8);
    @(negedge mclk);
    chk(32'({dcdc_en, txmask_reduce}), 32'h3);
    for (int k = 0; k < 2; k++) begin
      do_reset(3);
      set_ctrl(k ? 32'h33 : 32'h3);
      strobe_pin <= k[0];
      verdict(STEP * 4, 32'h10, 0, exp_ctrl & ~32'hf);
    end
    start(32'h2, 8'hff);
    vin_under <= 1'b1;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(32'({dcdc_en, source_en}), 32'h0);
    @(posedge mclk);
    vin_under <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(ADDR_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule
